// ===== hdl/eqcr_pkg.sv
// package: register map, field positions and types of the equalizer config bank
package eqcr_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [3:0] EQCR_ADDR_CONTROL = 4'h0;
  localparam logic [3:0] EQCR_ADDR_THRESHOLD = 4'h1;
  localparam logic [3:0] EQCR_ADDR_DEEMPH = 4'h2;
  localparam logic [3:0] EQCR_ADDR_SWING = 4'h3;
  localparam logic [3:0] EQCR_ADDR_RATE = 4'h7;
  localparam logic [3:0] EQCR_ADDR_RSVD_A = 4'h8;
  localparam logic [3:0] EQCR_ADDR_RSVD_B = 4'h9;
  localparam logic [3:0] EQCR_ADDR_RSVD_C = 4'hA;
  localparam logic [3:0] EQCR_ADDR_LOS_LEVEL = 4'hB;
  localparam logic [3:0] EQCR_ADDR_RSVD_D = 4'hC;
  localparam logic [3:0] EQCR_ADDR_RSVD_E = 4'hD;
  localparam logic [3:0] EQCR_ADDR_RATE_RB = 4'hE;
  localparam logic [3:0] EQCR_ADDR_LOS_RB = 4'hF;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int EQCR_BIT_LOS_SRC = 7;
  localparam int EQCR_BIT_SWING_SRC = 6;
  localparam int EQCR_BIT_DEEMPH_SRC = 5;
  localparam int EQCR_BIT_THRESH_SRC = 4;
  localparam int EQCR_BIT_OUT_DISABLE = 3;
  localparam int EQCR_BIT_LOS_RANGE = 2;
  localparam int EQCR_BIT_OC_OFF = 1;
  localparam int EQCR_BIT_METHOD = 0;
  localparam int EQCR_BIT_RATE_SEL = 7;

  // ---------------------------------------------------------------
  // field masks and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] EQCR_MASK_RATE = 8'h8F;
  localparam logic [7:0] EQCR_MASK_DEEMPH = 8'h0F;
  localparam logic [7:0] EQCR_MASK_SWING = 8'h03;
  localparam logic [7:0] EQCR_RST_CONTROL = 8'h00;
  localparam logic [7:0] EQCR_RST_THRESHOLD = 8'h00;
  localparam logic [7:0] EQCR_RST_DEEMPH = 8'h00;
  localparam logic [7:0] EQCR_RST_SWING = 8'h01;
  localparam logic [7:0] EQCR_RST_RATE = 8'h00;
  localparam logic [7:0] EQCR_RST_LOS_LEVEL = 8'h00;
  // rate code in effect when no register selection is made
  localparam logic [3:0] EQCR_DEFAULT_RATE = 4'h0;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
  } eqcr_req_type;

  typedef struct packed {
    logic [7:0] threshold_code;
    logic [3:0] deemph_code;
    logic [1:0] swing_code;
    logic [7:0] los_level_code;
    logic [3:0] active_rate_code;
    logic threshold_from_pin;
    logic deemph_from_pin;
    logic swing_from_pin;
    logic los_level_from_pin;
    logic output_disable;
    logic los_range_high;
    logic offset_cancel_off;
  } eqcr_cfg_type;

endpackage : eqcr_pkg

// ===== hdl/eqcr_bank.sv
// file: register bank of the equalizer configuration and readback registers
`timescale 1ns/1ps
`default_nettype none

// How it works
// - control bit 7 high takes SIGNAL_LOSS_FLAG level from pin, low from register 11.
// - control bit 6 high takes output swing from pin, low from register 3.
// - control bit 5 high takes de-emphasis from pins, low from register 2.
// - control bit 4 high takes threshold from pin, low from register 1.
// - control bit 3 high disables the output driver, low keeps it enabled.
// - control bit 2 high picks high SIGNAL_LOSS_FLAG assert range, low picks low range.
// - control bit 1 high disables input offset cancellation, low keeps it on.
// - control bit 0 high makes register settings active, low keeps pin control.
// - threshold code is eight bits, MSB at bit 7; code 1 is maximum positive shift.
// - rate register 0x07 holds select flag in bit 7 and code in bits 3..0.
// - address 0x0B holds a full eight-bit SIGNAL_LOSS_FLAG assert level.
// - read-only 0x0E shows the rate code in effect in bits 3..0.
// - read-only 0x0F shows bits 7..1 of the SIGNAL_LOSS_FLAG level in effect in bits 6..0.
// - addresses 0x08, 0x09, 0x0A, 0x0C, 0x0D carry no fields.
// - addresses 0 to 3, 7 and 11 are read-write, 14 and 15 read-only.
// - with control bit 0 and rate select both set, the rate code sets the input filter bandwidth.
module eqcr_bank (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // register port from the two-wire engine
  input wire eqcr_pkg::eqcr_req_type req_in,
  output logic [7:0] rdata_out,
  // analog pin settings, already digitised by the caller
  input wire logic [7:0] los_level_pin_in,
  input wire logic [1:0] swing_pin_in,
  input wire logic [7:0] threshold_voltage_pin_in,
  input wire logic [3:0] deemph_pins_in,
  input wire logic output_disable_pin_in,
  input wire logic los_range_pin_in,
  // settings in effect
  output eqcr_pkg::eqcr_cfg_type cfg_out
);
  import eqcr_pkg::*;

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [7:0] control_settings_q, control_settings_d;
  logic [7:0] input_threshold_adjust_q, input_threshold_adjust_d;
  logic [7:0] deemph_setting_q, deemph_setting_d;
  logic [7:0] swing_setting_q, swing_setting_d;
  logic [7:0] max_data_rate_setting_q, max_data_rate_setting_d;
  logic [7:0] los_level_setting_q, los_level_setting_d;
  logic [7:0] rdata_q, rdata_d;
  eqcr_cfg_type cfg_q, cfg_d;

  logic control_method_select;
  logic los_level_source_select;
  logic swing_source_select;
  logic deemph_source_select;
  logic threshold_source_select;
  logic los_range_high;
  logic offset_cancel_off;
  logic output_disable;

  // helper: a write strobe at one address
  function automatic logic eqcr_hit(input eqcr_req_type r, input logic [3:0] a);
    eqcr_hit = r.wr && (r.addr == a);
  endfunction : eqcr_hit

  // ---------------------------------------------------------------
  // write side
  // ---------------------------------------------------------------
  always_comb begin
    control_settings_d = control_settings_q;
    input_threshold_adjust_d = input_threshold_adjust_q;
    deemph_setting_d = deemph_setting_q;
    swing_setting_d = swing_setting_q;
    max_data_rate_setting_d = max_data_rate_setting_q;
    los_level_setting_d = los_level_setting_q;
    if (eqcr_hit(req_in, EQCR_ADDR_CONTROL)) begin
      control_settings_d = req_in.wdata;
    end
    if (eqcr_hit(req_in, EQCR_ADDR_THRESHOLD)) begin
      input_threshold_adjust_d = req_in.wdata;
    end
    if (eqcr_hit(req_in, EQCR_ADDR_DEEMPH)) begin
      deemph_setting_d = req_in.wdata & EQCR_MASK_DEEMPH;
    end
    if (eqcr_hit(req_in, EQCR_ADDR_SWING)) begin
      swing_setting_d = req_in.wdata & EQCR_MASK_SWING;
    end
    if (eqcr_hit(req_in, EQCR_ADDR_RATE)) begin
      max_data_rate_setting_d = req_in.wdata & EQCR_MASK_RATE;
    end
    // whole byte is the SIGNAL_LOSS_FLAG level
    if (eqcr_hit(req_in, EQCR_ADDR_LOS_LEVEL)) begin
      los_level_setting_d = req_in.wdata;
    end
    // reserved and read-only addresses have no write path
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      control_settings_q <= EQCR_RST_CONTROL;
      input_threshold_adjust_q <= EQCR_RST_THRESHOLD;
      deemph_setting_q <= EQCR_RST_DEEMPH;
      swing_setting_q <= EQCR_RST_SWING;
      max_data_rate_setting_q <= EQCR_RST_RATE;
      los_level_setting_q <= EQCR_RST_LOS_LEVEL;
    end else begin
      control_settings_q <= control_settings_d;
      input_threshold_adjust_q <= input_threshold_adjust_d;
      deemph_setting_q <= deemph_setting_d;
      swing_setting_q <= swing_setting_d;
      max_data_rate_setting_q <= max_data_rate_setting_d;
      los_level_setting_q <= los_level_setting_d;
    end
  end

  // ---------------------------------------------------------------
  // control field decode
  // ---------------------------------------------------------------
  // master select between pins and registers
  assign control_method_select = control_settings_q[EQCR_BIT_METHOD];
  assign los_level_source_select = control_settings_q[EQCR_BIT_LOS_SRC];
  assign swing_source_select = control_settings_q[EQCR_BIT_SWING_SRC];
  assign deemph_source_select = control_settings_q[EQCR_BIT_DEEMPH_SRC];
  assign threshold_source_select = control_settings_q[EQCR_BIT_THRESH_SRC];
  assign output_disable = control_settings_q[EQCR_BIT_OUT_DISABLE];
  assign los_range_high = control_settings_q[EQCR_BIT_LOS_RANGE];
  assign offset_cancel_off = control_settings_q[EQCR_BIT_OC_OFF];

  // ---------------------------------------------------------------
  // settings in effect
  // ---------------------------------------------------------------
  // pin control is the default; register fields other than the offset bit only act once the
  // master select is set, and each source bit can hand one back to its pin
  always_comb begin
    cfg_d.threshold_from_pin = !control_method_select || threshold_source_select;
    cfg_d.deemph_from_pin = !control_method_select || deemph_source_select;
    cfg_d.swing_from_pin = !control_method_select || swing_source_select;
    cfg_d.los_level_from_pin = !control_method_select || los_level_source_select;
    cfg_d.threshold_code = cfg_d.threshold_from_pin ? threshold_voltage_pin_in
                                                   : input_threshold_adjust_q;
    cfg_d.deemph_code = cfg_d.deemph_from_pin ? deemph_pins_in : deemph_setting_q[3:0];
    cfg_d.swing_code = cfg_d.swing_from_pin ? swing_pin_in : swing_setting_q[1:0];
    // SIGNAL_LOSS_FLAG level from pin or register
    cfg_d.los_level_code = cfg_d.los_level_from_pin ? los_level_pin_in : los_level_setting_q;
    cfg_d.output_disable = control_method_select ? output_disable : output_disable_pin_in;
    cfg_d.los_range_high = control_method_select ? los_range_high : los_range_pin_in;
    // offset cancellation has no pin, so the bit always acts
    cfg_d.offset_cancel_off = offset_cancel_off;
    // rate code steers bandwidth only while its select flag is set
    cfg_d.active_rate_code = (control_method_select && max_data_rate_setting_q[EQCR_BIT_RATE_SEL])
                             ? max_data_rate_setting_q[3:0] : EQCR_DEFAULT_RATE;
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg_q <= '0;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  assign cfg_out = cfg_q;

  // ---------------------------------------------------------------
  // read side
  // ---------------------------------------------------------------
  always_comb begin
    // reserved addresses and unused bits read zero
    rdata_d = 8'h00;
    // 0..3, 7 and 11 read back what was written, 14 and 15 show live state
    case (req_in.addr)
      EQCR_ADDR_CONTROL: rdata_d = control_settings_q;
      EQCR_ADDR_THRESHOLD: rdata_d = input_threshold_adjust_q;
      EQCR_ADDR_DEEMPH: rdata_d = deemph_setting_q;
      EQCR_ADDR_SWING: rdata_d = swing_setting_q;
      EQCR_ADDR_RATE: rdata_d = max_data_rate_setting_q;
      EQCR_ADDR_LOS_LEVEL: rdata_d = los_level_setting_q;
      EQCR_ADDR_RATE_RB: rdata_d = {4'h0, cfg_q.active_rate_code};
      EQCR_ADDR_LOS_RB: rdata_d = {1'b0, cfg_q.los_level_code[7:1]};
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_out = rdata_q;

endmodule : eqcr_bank

`default_nettype wire

// ===== verification/eqcr_checker.sv
// checker: port assertions of the equalizer config bank
`timescale 1ns/1ps
`default_nettype none
module eqcr_checker (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  // watched ports
  input wire eqcr_pkg::eqcr_req_type req_in,
  input wire logic [7:0] rdata_out,
  input wire eqcr_pkg::eqcr_cfg_type cfg_out,
  input wire logic [7:0] los_level_pin_in,
  input wire logic [7:0] threshold_voltage_pin_in
);
  import eqcr_pkg::*;
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rstn_in);
  // ---------------------------------------------------------------
  // write sequences and assertions
  // ---------------------------------------------------------------
  // a lone write gives the cfg stage two edges to settle
  sequence lone_wr(a, b, m);
    req_in.wr && req_in.addr == a && req_in.wdata[b] == m ##1 !(req_in.wr && req_in.addr == a);
  endsequence
  a_method_pin: assert property (lone_wr(4'h0, 0, 1'b0) |=> {cfg_out.los_level_from_pin,
    cfg_out.swing_from_pin, cfg_out.deemph_from_pin, cfg_out.threshold_from_pin} == 4'hF)
    else $error("pin control not taken");
  a_src_select: assert property (lone_wr(4'h0, 0, 1'b1) |=> {cfg_out.los_level_from_pin,
    cfg_out.swing_from_pin, cfg_out.deemph_from_pin, cfg_out.threshold_from_pin} == $past(req_in.wdata[7:4], 2))
    else $error("source selects wrong");
  a_ctl_flags: assert property (lone_wr(4'h0, 0, 1'b1) |=> {cfg_out.output_disable,
    cfg_out.los_range_high, cfg_out.offset_cancel_off} == $past(req_in.wdata[3:1], 2))
    else $error("control flags wrong");
  a_rate_off: assert property (lone_wr(4'h7, 7, 1'b0) |=> cfg_out.active_rate_code == 4'h0)
    else $error("rate code active without select");
  a_rsvd_zero: assert property (req_in.addr inside {4'h8, 4'h9, 4'hA, 4'hC, 4'hD} |=> rdata_out == 8'h00)
    else $error("reserved read nonzero");
  a_rate_rb: assert property (req_in.addr == 4'hE |=> rdata_out == {4'h0, $past(cfg_out.active_rate_code)})
    else $error("rate readback wrong");
  a_los_rb: assert property (req_in.addr == 4'hF |=> rdata_out == {1'b0, $past(cfg_out.los_level_code[7:1])})
    else $error("level readback wrong");
  a_thr_pin: assert property (cfg_out.threshold_from_pin |->
    cfg_out.threshold_code == $past(threshold_voltage_pin_in))
    else $error("threshold pin not followed");
  a_los_pin: assert property (cfg_out.los_level_from_pin |-> cfg_out.los_level_code == $past(los_level_pin_in))
    else $error("level pin not followed");
endmodule : eqcr_checker
bind eqcr_bank eqcr_checker eqcr_checker_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .req_in(req_in),
  .rdata_out(rdata_out), .cfg_out(cfg_out), .los_level_pin_in(los_level_pin_in),
  .threshold_voltage_pin_in(threshold_voltage_pin_in));
`default_nettype wire

// ===== verification/eqcr_host.sv
// host model: register master on the bank's request port
`timescale 1ns/1ps
`default_nettype none
module eqcr_host (
  // clock and register port
  input wire logic clk_sys_in,
  output var eqcr_pkg::eqcr_req_type req_out,
  input wire logic [7:0] rdata_in
);
  import eqcr_pkg::*;
  initial req_out = '0;
  // the strobe is taken at the edge after it rises, then dropped
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in) req_out <= '{addr: a, wdata: d, wr: 1'b1};
    @(posedge clk_sys_in) req_out.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk_sys_in) req_out.addr <= a;
    @(posedge clk_sys_in);
    #1 v = rdata_in;
  endtask : rd
endmodule : eqcr_host
`default_nettype wire

// ===== verification/tb.sv
// testbench: reset, register and control scenarios of the config bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import eqcr_pkg::*;
  logic clk_sys_in;
  logic rstn_in;
  eqcr_req_type req;
  eqcr_cfg_type cfg;
  logic [7:0] rdata;
  logic [7:0] v;
  // los 23:16, swing 15:14, threshold 13:6, deemph 5:2, disable 1, range 0
  logic [23:0] pins;
  int errors;
  int comparisons;
  eqcr_bank eqcr_bank_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .req_in(req), .rdata_out(rdata),
    .los_level_pin_in(pins[23:16]), .swing_pin_in(pins[15:14]), .threshold_voltage_pin_in(pins[13:6]),
    .deemph_pins_in(pins[5:2]), .output_disable_pin_in(pins[1]), .los_range_pin_in(pins[0]), .cfg_out(cfg));
  eqcr_host eqcr_host_i (.clk_sys_in(clk_sys_in), .req_out(req), .rdata_in(rdata));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rc(input logic [3:0] a, input logic [7:0] e);
    eqcr_host_i.rd(a, v);
    chk(v, e);
  endtask : rc
  function automatic logic [7:0] flags();
    return {1'b0, cfg.los_level_from_pin, cfg.swing_from_pin, cfg.deemph_from_pin, cfg.threshold_from_pin,
      cfg.output_disable, cfg.los_range_high, cfg.offset_cancel_off};
  endfunction : flags
  task automatic test_done();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : test_done
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    for (int a = 0; a < 16; a++) begin
      rc(a[3:0], (a == 3) ? 8'h01 : (a == 15) ? {1'b0, pins[23:17]} : 8'h00);
    end
    chk(flags(), 8'h7E);
    chk({cfg.swing_code, cfg.deemph_code, 2'b00}, {pins[15:14], pins[5:2], 2'b00});
    @(posedge clk_sys_in) pins[13:6] <= 8'h5A;
    repeat (2) @(posedge clk_sys_in);
    #1 chk(cfg.threshold_code, 8'h5A);
  endtask : t_reset
  task automatic t_regs();
    eqcr_host_i.wr(4'h0, 8'h01);
    eqcr_host_i.wr(4'h1, 8'h01);
    eqcr_host_i.wr(4'hB, 8'hFF);
    eqcr_host_i.wr(4'h7, 8'hFF);
    rc(4'h7, 8'h8F);
    rc(4'hE, 8'h0F);
    rc(4'hF, 8'h7F);
    rc(4'h1, 8'h01);
    chk(cfg.threshold_code, 8'h01);
    chk(cfg.los_level_code, 8'hFF);
    // register-side swing and de-emphasis, unused upper bits dropped
    eqcr_host_i.wr(4'h2, 8'hFF);
    eqcr_host_i.wr(4'h3, 8'hFF);
    rc(4'h2, 8'h0F);
    rc(4'h3, 8'h03);
    chk({cfg.swing_code, cfg.deemph_code, 2'b00}, 8'hFC);
    eqcr_host_i.wr(4'h7, 8'h05);
    rc(4'hE, 8'h00);
  endtask : t_regs
  task automatic t_control();
    logic [7:0] d;
    for (int b = 1; b < 8; b++) begin
      d = (8'h01 << b) | 8'h01;
      eqcr_host_i.wr(4'h0, d);
      rc(4'h0, d);
      chk(flags(), {1'b0, d[7:1]});
    end
    // method off: sources, disable and range revert to pins, offset bit stays
    eqcr_host_i.wr(4'h0, 8'hFE);
    rc(4'h0, 8'hFE);
    chk(flags(), 8'h7F);
  endtask : t_control
  task automatic t_rsvd();
    logic [3:0] ra [7] = '{4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE, 4'hF};
    foreach (ra[i]) eqcr_host_i.wr(ra[i], 8'hFF);
    foreach (ra[i]) rc(ra[i], (ra[i] == 4'hF) ? {1'b0, pins[23:17]} : 8'h00);
  endtask : t_rsvd
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  // the scenarios need some 135 cycles; the 3000-cycle limit, over twenty times that, means a hang
  initial begin
    #(3000 * 50);
    errors++;
    test_done();
  end
  initial begin
    errors = 0;
    comparisons = 0;
    rstn_in = 1'b0;
    pins = {8'h3C, 2'h2, 8'hA5, 4'h6, 1'b1, 1'b1};
    repeat (12) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    t_reset();
    t_regs();
    t_control();
    t_rsvd();
    test_done();
  end
endmodule : tb
`default_nettype wire
